// *** inc/bmwd_pkg.sv ***
// Package of register offsets, field layout and reset values for the memory window decoder.
`default_nettype none
package bmwd_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 16;
  localparam logic [7:0]  NP_BASE_OFF     = 8'h20;
  localparam logic [7:0]  NP_LIMIT_OFF    = 8'h22;
  localparam logic [7:0]  PF_BASE_OFF     = 8'h24;
  localparam logic [7:0]  PF_LIMIT_OFF    = 8'h26;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int          FIELD_LSB       = 4;
  localparam int          FIELD_W         = 12;
  localparam int          MEM_ADDR_W      = 32;
  localparam int          LOW_ADDR_W      = 20;
  localparam logic [15:0] BASE_RESET      = 16'hFFF0;
  localparam logic [15:0] LIMIT_RESET     = 16'h0000;
  localparam logic [11:0] BASE_FIELD_RST  = BASE_RESET[15:4];
  localparam logic [11:0] LIMIT_FIELD_RST = LIMIT_RESET[15:4];

  // Route of a processor memory access.
  typedef enum logic [1:0] {
    BMWD_ROUTE_NONE,
    BMWD_ROUTE_NONPREFETCH,
    BMWD_ROUTE_PREFETCH,
    BMWD_ROUTE_BOTH
  } bmwd_route_t;

endpackage : bmwd_pkg
`default_nettype wire

// *** rtl/bmwd_window_reg.sv ***
// One base/limit field register with a read-only zero low nibble.
`timescale 1ns/1ns
`default_nettype none
module bmwd_window_reg
  import bmwd_pkg::*;
#(
  parameter logic [11:0] RESET_FIELD = 12'h000
) (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   wr_en,
  input  wire logic [bmwd_pkg::DATA_W-1:0] wr_data,
  output var  logic [bmwd_pkg::FIELD_W-1:0] field_q
);
  import bmwd_pkg::*;

  logic [FIELD_W-1:0] field_d;

  always_comb begin
    field_d = field_q;
    if (wr_en) begin
      field_d = wr_data[DATA_W-1:FIELD_LSB];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      field_q <= RESET_FIELD;
    end else begin
      field_q <= field_d;
    end
  end

endmodule : bmwd_window_reg
`default_nettype wire

// *** rtl/bmwd_window_match.sv ***
// Inclusive window compare of a 32-bit address against a 1-MB base/limit pair.
`timescale 1ns/1ns
`default_nettype none
module bmwd_window_match
  import bmwd_pkg::*;
(
  input  wire logic [bmwd_pkg::MEM_ADDR_W-1:0] addr,
  input  wire logic [bmwd_pkg::FIELD_W-1:0]    base_field,
  input  wire logic [bmwd_pkg::FIELD_W-1:0]    limit_field,
  output var  logic                            hit
);
  import bmwd_pkg::*;

  logic [MEM_ADDR_W-1:0] base_addr;
  logic [MEM_ADDR_W-1:0] limit_addr;

  always_comb begin
    base_addr  = {base_field, {LOW_ADDR_W{1'b0}}};
    limit_addr = {limit_field, {LOW_ADDR_W{1'b1}}};
    // Inverted window empty
    // The field compare repeats what the address compares already imply, but keeps the empty case explicit.
    hit = (addr >= base_addr) && (addr <= limit_addr) && (base_field <= limit_field);
  end

endmodule : bmwd_window_match
`default_nettype wire

// *** rtl/bmwd_decoder.sv ***
// Top of the bridge memory window decoder: registers, bus slave and routing decision.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
module bmwd_decoder
  import bmwd_pkg::*;
(
  input  wire logic                            CLK,
  input  wire logic                            RESET_N,
  input  wire logic [bmwd_pkg::ADDR_W-1:0]     REG_ADDR,
  input  wire logic [bmwd_pkg::DATA_W-1:0]     REG_WDATA,
  input  wire logic                            REG_WR,
  input  wire logic                            REG_RD,
  output var  logic [bmwd_pkg::DATA_W-1:0]     REG_RDATA,
  input  wire logic                            MEM_REQ,
  input  wire logic [bmwd_pkg::MEM_ADDR_W-1:0] MEM_ADDR,
  output var  logic                            FWD_VALID,
  output var  logic                            FWD_NONPREFETCH,
  output var  logic                            FWD_PREFETCH,
  output var  logic [bmwd_pkg::MEM_ADDR_W-1:0] FWD_ADDR
);
  import bmwd_pkg::*;

  // ************************************************************
  // Window registers
  // ************************************************************
  logic [FIELD_W-1:0] np_base;
  logic [FIELD_W-1:0] np_limit;
  logic [FIELD_W-1:0] pf_base;
  logic [FIELD_W-1:0] pf_limit;
  logic               np_base_wr;
  logic               np_limit_wr;
  logic               pf_base_wr;
  logic               pf_limit_wr;

  always_comb begin
    np_base_wr  = REG_WR && (REG_ADDR == NP_BASE_OFF);
    np_limit_wr = REG_WR && (REG_ADDR == NP_LIMIT_OFF);
    pf_base_wr  = REG_WR && (REG_ADDR == PF_BASE_OFF);
    pf_limit_wr = REG_WR && (REG_ADDR == PF_LIMIT_OFF);
  end

  bmwd_window_reg #(.RESET_FIELD(BASE_FIELD_RST)) u_np_base (
    .clk     (CLK),
    .reset_n (RESET_N),
    .wr_en   (np_base_wr),
    .wr_data (REG_WDATA),
    .field_q (np_base)
  );

  bmwd_window_reg #(.RESET_FIELD(LIMIT_FIELD_RST)) u_np_limit (
    .clk     (CLK),
    .reset_n (RESET_N),
    .wr_en   (np_limit_wr),
    .wr_data (REG_WDATA),
    .field_q (np_limit)
  );

  bmwd_window_reg #(.RESET_FIELD(BASE_FIELD_RST)) u_pf_base (
    .clk     (CLK),
    .reset_n (RESET_N),
    .wr_en   (pf_base_wr),
    .wr_data (REG_WDATA),
    .field_q (pf_base)
  );

  bmwd_window_reg #(.RESET_FIELD(LIMIT_FIELD_RST)) u_pf_limit (
    .clk     (CLK),
    .reset_n (RESET_N),
    .wr_en   (pf_limit_wr),
    .wr_data (REG_WDATA),
    .field_q (pf_limit)
  );

  // ************************************************************
  // Register read port
  // ************************************************************
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;

  always_comb begin
    rdata_d = '0;
    if (REG_RD) begin
      case (REG_ADDR)
        NP_BASE_OFF:  rdata_d = {np_base, 4'h0};
        NP_LIMIT_OFF: rdata_d = {np_limit, 4'h0};
        PF_BASE_OFF:  rdata_d = {pf_base, 4'h0};
        PF_LIMIT_OFF: rdata_d = {pf_limit, 4'h0};
        default:      rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA = rdata_q;

  // ************************************************************
  // Address decode
  // ************************************************************
  logic np_hit;
  logic pf_hit;

  bmwd_window_match u_np_match (
    .addr        (MEM_ADDR),
    .base_field  (np_base),
    .limit_field (np_limit),
    .hit         (np_hit)
  );

  bmwd_window_match u_pf_match (
    .addr        (MEM_ADDR),
    .base_field  (pf_base),
    .limit_field (pf_limit),
    .hit         (pf_hit)
  );

  // ************************************************************
  // Forwarding register
  // ************************************************************
  bmwd_route_t           route;
  logic                  fwd_valid_d;
  logic                  fwd_valid_q;
  logic                  fwd_np_d;
  logic                  fwd_np_q;
  logic                  fwd_pf_d;
  logic                  fwd_pf_q;
  logic [MEM_ADDR_W-1:0] fwd_addr_d;
  logic [MEM_ADDR_W-1:0] fwd_addr_q;

  // No overlap check
  // Overlapping windows are a software fault; both flags are passed on unfiltered.
  always_comb begin
    route       = bmwd_route_t'({pf_hit, np_hit});
    fwd_valid_d = 1'b0;
    fwd_np_d    = 1'b0;
    fwd_pf_d    = 1'b0;
    fwd_addr_d  = fwd_addr_q;
    if (MEM_REQ) begin
      case (route)
        BMWD_ROUTE_NONE: begin
          fwd_valid_d = 1'b0;
        end
        BMWD_ROUTE_NONPREFETCH: begin
          fwd_valid_d = 1'b1;
          fwd_np_d    = 1'b1;
        end
        BMWD_ROUTE_PREFETCH: begin
          fwd_valid_d = 1'b1;
          fwd_pf_d    = 1'b1;
        end
        BMWD_ROUTE_BOTH: begin
          fwd_valid_d = 1'b1;
          fwd_np_d    = 1'b1;
          fwd_pf_d    = 1'b1;
        end
        default: begin
          fwd_valid_d = 1'b0;
        end
      endcase
      fwd_addr_d = MEM_ADDR;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      fwd_valid_q <= 1'b0;
      fwd_np_q    <= 1'b0;
      fwd_pf_q    <= 1'b0;
      fwd_addr_q  <= '0;
    end else begin
      fwd_valid_q <= fwd_valid_d;
      fwd_np_q    <= fwd_np_d;
      fwd_pf_q    <= fwd_pf_d;
      fwd_addr_q  <= fwd_addr_d;
    end
  end

  assign FWD_VALID       = fwd_valid_q;
  assign FWD_NONPREFETCH = fwd_np_q;
  assign FWD_PREFETCH    = fwd_pf_q;
  assign FWD_ADDR        = fwd_addr_q;

  // ************************************************************
  // Assertions
  // ************************************************************
  property p_np_forward;
    @(posedge CLK) disable iff (!RESET_N)
    (MEM_REQ && ({MEM_ADDR[31:20]} >= np_base) && (MEM_ADDR[31:20] <= np_limit))
      |=> FWD_VALID && FWD_NONPREFETCH && (FWD_ADDR == $past(MEM_ADDR));
  endproperty
  a_np_forward: assert property (p_np_forward) else $error("np hit not forwarded");

  property p_pf_forward;
    @(posedge CLK) disable iff (!RESET_N)
    (MEM_REQ && (MEM_ADDR[31:20] >= pf_base) && (MEM_ADDR[31:20] <= pf_limit))
      |=> FWD_VALID && FWD_PREFETCH;
  endproperty
  a_pf_forward: assert property (p_pf_forward) else $error("pf hit not forwarded");

  property p_np_outside;
    @(posedge CLK) disable iff (!RESET_N)
    (MEM_REQ && ((MEM_ADDR[31:20] < np_base) || (MEM_ADDR[31:20] > np_limit)))
      |=> !FWD_NONPREFETCH;
  endproperty
  a_np_outside: assert property (p_np_outside) else $error("np miss forwarded");

  property p_pf_outside;
    @(posedge CLK) disable iff (!RESET_N)
    (MEM_REQ && ((MEM_ADDR[31:20] < pf_base) || (MEM_ADDR[31:20] > pf_limit)))
      |=> !FWD_PREFETCH;
  endproperty
  a_pf_outside: assert property (p_pf_outside) else $error("pf miss forwarded");

  property p_inverted_empty;
    @(posedge CLK) disable iff (!RESET_N)
    (np_base > np_limit) |=> !FWD_NONPREFETCH;
  endproperty
  a_inverted_empty: assert property (p_inverted_empty) else $error("inverted window hit");

  property p_low_nibble;
    @(posedge CLK) disable iff (!RESET_N)
    $past(REG_RD) |-> (REG_RDATA[3:0] == 4'h0);
  endproperty
  a_low_nibble: assert property (p_low_nibble) else $error("low nibble not zero");

  property p_write_read;
    @(posedge CLK) disable iff (!RESET_N)
    (REG_WR && (REG_ADDR == PF_LIMIT_OFF)) ##1 (REG_RD && (REG_ADDR == PF_LIMIT_OFF) && !REG_WR)
      |=> (REG_RDATA[15:4] == $past(REG_WDATA[15:4], 2));
  endproperty
  a_write_read: assert property (p_write_read) else $error("readback mismatch");

  property p_reset_vals;
    @(posedge CLK)
    (RESET_N && $past(!RESET_N))
      |-> (np_base == 12'hFFF) && (pf_base == 12'hFFF) && (np_limit == 12'h000)
      && (pf_limit == 12'h000);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

  property p_np_reset_empty;
    @(posedge CLK)
    (RESET_N && $past(!RESET_N)) |-> (np_base == BASE_FIELD_RST);
  endproperty
  a_np_reset_empty: assert property (p_np_reset_empty) else $error("np base reset wrong");

  property p_np_base_edge;
    @(posedge CLK) disable iff (!RESET_N)
    (MEM_REQ && (np_base <= np_limit) && (MEM_ADDR == {np_base, {LOW_ADDR_W{1'b0}}}))
      |=> FWD_NONPREFETCH;
  endproperty
  a_np_base_edge: assert property (p_np_base_edge) else $error("np base edge missed");

  property p_pf_limit_edge;
    @(posedge CLK) disable iff (!RESET_N)
    (MEM_REQ && (pf_base <= pf_limit) && (MEM_ADDR == {pf_limit, {LOW_ADDR_W{1'b1}}}))
      |=> FWD_PREFETCH;
  endproperty
  a_pf_limit_edge: assert property (p_pf_limit_edge) else $error("pf limit edge missed");

  property p_route_idle;
    @(posedge CLK) disable iff (!RESET_N)
    !MEM_REQ |=> !FWD_VALID && !FWD_NONPREFETCH && !FWD_PREFETCH && $stable(FWD_ADDR);
  endproperty
  a_route_idle: assert property (p_route_idle) else $error("idle cycle forwarded");

  property p_rdata_idle;
    @(posedge CLK) disable iff (!RESET_N)
    !REG_RD |=> (REG_RDATA == '0);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");

  property p_write_lands;
    @(posedge CLK) disable iff (!RESET_N)
    (REG_WR && (REG_ADDR == NP_BASE_OFF))
      |=> (np_base == $past(REG_WDATA[DATA_W-1:FIELD_LSB]));
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write did not land");

endmodule : bmwd_decoder
`default_nettype wire

// *** testbench/bmwd_host_model.sv ***
// Processor-side model that issues single memory accesses to the decoder.
`timescale 1ns/1ns
`default_nettype none
module bmwd_host_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic [31:0] addr_in,
  output var  logic        mem_req,
  output var  logic [31:0] mem_addr
);
  // Between accesses the address toggles, so a stale address never looks valid.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mem_req  <= 1'b0;
      mem_addr <= 32'h0;
    end else begin
      mem_req  <= go;
      mem_addr <= go ? addr_in : ~mem_addr;
    end
  end
endmodule : bmwd_host_model
`default_nettype wire

// *** testbench/tb.sv ***
// Self-checking bench for the memory window decoder.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import bmwd_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  r_addr = 8'h00;
  logic [15:0] r_wdata = 16'h0;
  logic        r_wr = 1'b0;
  logic        r_rd = 1'b0;
  logic [15:0] r_rdata;
  logic        go = 1'b0;
  logic [31:0] h_addr = 32'h0;
  logic        m_req;
  logic [31:0] m_addr;
  logic        f_val;
  logic        f_np;
  logic        f_pf;
  logic [31:0] f_addr;
  int          num_errors = 0;
  int          tests_run = 0;

  always #4 clk = ~clk;

  bmwd_decoder DUT (.CLK(clk), .RESET_N(rst_n), .REG_ADDR(r_addr), .REG_WDATA(r_wdata),
    .REG_WR(r_wr), .REG_RD(r_rd), .REG_RDATA(r_rdata), .MEM_REQ(m_req), .MEM_ADDR(m_addr),
    .FWD_VALID(f_val), .FWD_NONPREFETCH(f_np), .FWD_PREFETCH(f_pf), .FWD_ADDR(f_addr));

  bmwd_host_model host (.clk(clk), .rst_n(rst_n), .go(go), .addr_in(h_addr),
    .mem_req(m_req), .mem_addr(m_addr));

  // ****************
  // Shared tasks
  // ****************
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    r_wr    <= 1'b1;
    r_addr  <= a;
    r_wdata <= d;
    @(posedge clk);
    r_wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    r_rd   <= 1'b1;
    r_addr <= a;
    @(posedge clk);
    r_rd   <= 1'b0;
    #1;
    cmp("read data", {16'h0, exp}, {16'h0, r_rdata});
  endtask : reg_rd

  // Flags are judged in their one cycle and again one cycle later, when they must be low.
  task automatic mem(input logic [31:0] a, input logic np, input logic pf);
    @(posedge clk);
    go     <= 1'b1;
    h_addr <= a;
    @(posedge clk);
    go     <= 1'b0;
    @(posedge clk);
    #1;
    cmp("route", {29'h0, np | pf, np, pf}, {29'h0, f_val, f_np, f_pf});
    cmp("fwd addr", a, f_addr);
    @(posedge clk);
    #1;
    cmp("route idle", 32'h0, {29'h0, f_val, f_np, f_pf});
  endtask : mem

  // ****************
  // Scenarios
  // ****************
  task automatic t_defaults();
    reg_rd(NP_BASE_OFF, 16'hFFF0);
    reg_rd(NP_LIMIT_OFF, 16'h0000);
    reg_rd(PF_BASE_OFF, 16'hFFF0);
    reg_rd(PF_LIMIT_OFF, 16'h0000);
    mem(32'h0000_0000, 1'b0, 1'b0);
    mem(32'hFFF0_0000, 1'b0, 1'b0);
  endtask : t_defaults

  task automatic t_fields();
    reg_wr(NP_BASE_OFF, 16'hFFFF);
    reg_rd(NP_BASE_OFF, 16'hFFF0);
    reg_wr(PF_LIMIT_OFF, 16'hA5AF);
    reg_rd(PF_LIMIT_OFF, 16'hA5A0);
    @(posedge clk);
    #1;
    cmp("rdata idle", 32'h0, {16'h0, r_rdata});
    reg_wr(8'h28, 16'h1234);
    reg_rd(8'h28, 16'h0000);
    reg_rd(8'h21, 16'h0000);
  endtask : t_fields

  task automatic t_windows();
    reg_wr(NP_BASE_OFF, 16'h1000);
    reg_wr(NP_LIMIT_OFF, 16'h1FF0);
    reg_wr(PF_BASE_OFF, 16'h3000);
    reg_wr(PF_LIMIT_OFF, 16'h3000);
    mem(32'h0FFF_FFFF, 1'b0, 1'b0);
    mem(32'h1000_0000, 1'b1, 1'b0);
    mem(32'h1FFF_FFFF, 1'b1, 1'b0);
    mem(32'h2000_0000, 1'b0, 1'b0);
    mem(32'h2FFF_FFFF, 1'b0, 1'b0);
    mem(32'h3000_0000, 1'b0, 1'b1);
    mem(32'h300F_FFFF, 1'b0, 1'b1);
    mem(32'h3010_0000, 1'b0, 1'b0);
  endtask : t_windows

  task automatic t_inverted();
    reg_wr(NP_BASE_OFF, 16'h5000);
    reg_wr(NP_LIMIT_OFF, 16'h4000);
    mem(32'h4800_0000, 1'b0, 1'b0);
    mem(32'h5000_0000, 1'b0, 1'b0);
    mem(32'h3000_0000, 1'b0, 1'b1);
  endtask : t_inverted

  // Write then read with no idle cycle, then two memory requests in consecutive cycles.
  task automatic t_back2back();
    @(posedge clk);
    r_wr    <= 1'b1;
    r_addr  <= PF_LIMIT_OFF;
    r_wdata <= 16'h7E5F;
    @(posedge clk);
    r_wr    <= 1'b0;
    r_rd    <= 1'b1;
    @(posedge clk);
    r_rd    <= 1'b0;
    #1;
    cmp("b2b read", 32'h0000_7E50, {16'h0, r_rdata});
    @(posedge clk);
    go     <= 1'b1;
    h_addr <= 32'h3000_0000;
    @(posedge clk);
    h_addr <= 32'h0000_0000;
    @(posedge clk);
    go     <= 1'b0;
    #1;
    cmp("b2b route", 32'h5, {29'h0, f_val, f_np, f_pf});
    cmp("b2b addr", 32'h3000_0000, f_addr);
    @(posedge clk);
    #1;
    cmp("b2b route miss", 32'h0, {29'h0, f_val, f_np, f_pf});
    cmp("b2b addr miss", 32'h0000_0000, f_addr);
  endtask : t_back2back

  // Overlap is deliberate here: the hardware passes both flags on unfiltered.
  task automatic t_overlap();
    reg_wr(NP_BASE_OFF, 16'h3000);
    reg_wr(NP_LIMIT_OFF, 16'h3000);
    mem(32'h3000_0000, 1'b1, 1'b1);
  endtask : t_overlap

  task automatic close_out();
    $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_fields();
    t_windows();
    t_inverted();
    t_back2back();
    t_overlap();
    // A second reset mid-run must bring back the defaults.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_defaults();
    close_out();
  end

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    close_out();
  end
endmodule : tb
`default_nettype wire
